// ### verilog/ssfb_ctl.sv
// controller end: drives the sram pins from a simple command port
// assumes the sram end shares i_clk and ssfb_if joins the two ends
`timescale 1ns/1ps
`include "ssfb_regs.svh"

module ssfb_ctl
  import ssfb_pkg::*;
#(
  parameter int ADDR_W = `SSFB_ADDR_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_cmd_valid,
  input  ssfb_op_t               i_cmd_op,
  input  wire logic              i_cmd_write,
  input  wire logic [ADDR_W-1:0] i_cmd_addr,
  input  ssfb_lanes_t            i_cmd_lanes_n,
  input  ssfb_word_t             i_wdata,
  input  wire logic              i_hold,
  input  wire logic              i_burst_order,
  output logic                   o_cmd_ready,
  output ssfb_word_t             o_rdata,
  output logic                   o_rvalid,
  ssfb_if.ctl                    bus
);

  if (ADDR_W < `SSFB_ADDR_MIN || ADDR_W > `SSFB_ADDR_MAX) begin : g_bad_w
    $error("ssfb_ctl: ADDR_W out of range");
  end
  if ($bits(bus.addr) != ADDR_W) begin : g_bad_bus
    $error("ssfb_ctl: interface address width differs");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rw;
    logic              adv;
    logic              cs_on;
    logic              hold_n;
    ssfb_lanes_t       lanes_n;
    logic              order;
    logic              burst_on;
    logic              burst_rd;
    logic              pend_rd;
    logic              dq_oe;
    ssfb_word_t        dq_out;
    logic              oe_n;
    logic              rvalid;
    ssfb_word_t        rdata;
  } ssfb_ctl_st_t;

  ssfb_ctl_st_t st;
  ssfb_ctl_st_t next_st;
  logic         fresh;
  logic         fresh_rd;

  always_comb begin
    next_st  = st;
    fresh    = 1'b0;
    fresh_rd = 1'b0;
    next_st.rvalid = 1'b0;
    // mirror what the sram does with the pins it samples at this edge
    if (!st.hold_n) begin
      if (!st.adv) begin
        next_st.burst_on = st.cs_on;
        if (st.cs_on) begin
          next_st.burst_rd = st.rw;
          fresh            = 1'b1;
          fresh_rd         = st.rw;
        end
      end else if (st.burst_on) begin
        fresh    = 1'b1;
        fresh_rd = st.burst_rd;
      end
      // the previous read word is on the bus now
      next_st.rvalid  = st.pend_rd;
      if (st.pend_rd) begin
        next_st.rdata = bus.dq;
      end
      next_st.pend_rd = fresh && fresh_rd;
      next_st.oe_n    = !(fresh && fresh_rd);
      // drive write data only in a write data cycle, held while suspended
      next_st.dq_oe   = fresh && !fresh_rd;
      next_st.dq_out  = i_wdata;
    end
    // the hold pin is high to suspend, so it follows the user hold level
    next_st.hold_n = i_hold;
    next_st.order  = i_burst_order;
    if (!i_hold) begin
      next_st.adv   = 1'b0;
      next_st.cs_on = 1'b0;
      if (i_cmd_valid) begin
        case (i_cmd_op)
          SSFB_OP_LOAD: begin
            next_st.cs_on   = 1'b1;
            next_st.addr    = i_cmd_addr;
            next_st.rw      = !i_cmd_write;
            next_st.lanes_n = i_cmd_lanes_n;
          end
          SSFB_OP_ADV: begin
            next_st.adv     = 1'b1;
            next_st.lanes_n = i_cmd_lanes_n;
          end
          SSFB_OP_DESEL: begin
            next_st.cs_on = 1'b0;
          end
          default: begin
            next_st.cs_on = 1'b0;
          end
        endcase
      end
    end
  end

  // reset leaves a deselect on the pins and the bus released
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st      <= '0;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_cmd_ready            = !i_hold;
  assign o_rdata                = st.rdata;
  assign o_rvalid               = st.rvalid;
  assign bus.addr               = st.addr;
  assign bus.rw                 = st.rw;
  assign bus.advance_not_load   = st.adv;
  assign bus.chip_select_a_n    = !st.cs_on;
  assign bus.chip_select_b      = st.cs_on;
  assign bus.chip_select_c_n    = !st.cs_on;
  assign bus.clock_hold_n       = st.hold_n;
  assign bus.byte_lane_write_n  = st.lanes_n;
  assign bus.burst_order_select = st.order;
  assign bus.output_enable_n    = st.oe_n;
  assign bus.ctl_dq_out         = st.dq_out;
  assign bus.ctl_dq_oe          = st.dq_oe;

endmodule

// ### include/ssfb_regs.svh
// constants for the flow-through burst sram port
// assumes nothing beyond a SystemVerilog compiler; definitions only
`ifndef SSFB_REGS_SVH
`define SSFB_REGS_SVH

`define SSFB_ADDR_W   17
`define SSFB_DATA_W   36
`define SSFB_LANES    4
`define SSFB_BYTE_W   8
`define SSFB_LANE_W   9
`define SSFB_PAR_BASE 32
`define SSFB_BEAT_W   2
`define SSFB_ADDR_MIN 2
`define SSFB_ADDR_MAX 20

`endif

// ### include/ssfb_pkg.sv
// shared types for both ends of the flow-through burst sram port
// assumes ssfb_regs.svh is on the include path
`include "ssfb_regs.svh"

package ssfb_pkg;

  typedef logic [`SSFB_DATA_W-1:0] ssfb_word_t;
  typedef logic [`SSFB_LANES-1:0]  ssfb_lanes_t;
  typedef logic [`SSFB_BEAT_W-1:0] ssfb_beat_t;

  // user-side command of the controller end
  typedef enum logic [2:0] {
    SSFB_OP_DESEL = 3'h1,
    SSFB_OP_LOAD  = 3'h2,
    SSFB_OP_ADV   = 3'h4
  } ssfb_op_t;

endpackage

// ### include/ssfb_if.sv
// pin bundle between the sram end and the controller end
// the shared data wire is resolved here from the two output enables
`timescale 1ns/1ps
`include "ssfb_regs.svh"

interface ssfb_if
  import ssfb_pkg::*;
#(
  parameter int ADDR_W = `SSFB_ADDR_W
) ();

  logic [ADDR_W-1:0] addr;
  logic              rw;
  logic              advance_not_load;
  logic              chip_select_a_n;
  logic              chip_select_b;
  logic              chip_select_c_n;
  logic              clock_hold_n;
  ssfb_lanes_t       byte_lane_write_n;
  logic              burst_order_select;
  logic              output_enable_n;
  ssfb_word_t        mem_dq_out;
  logic              mem_dq_oe;
  ssfb_word_t        ctl_dq_out;
  logic              ctl_dq_oe;
  ssfb_word_t        dq;
  logic              dq_floating;
  logic              dq_contention;

  // a floating bus reads as zero; contention is flagged for the bench
  assign dq = mem_dq_oe ? mem_dq_out :
              (ctl_dq_oe ? ctl_dq_out : '0);
  assign dq_floating   = !mem_dq_oe && !ctl_dq_oe;
  assign dq_contention = mem_dq_oe && ctl_dq_oe;

  modport mem (
    input  addr, rw, advance_not_load, chip_select_a_n, chip_select_b,
    input  chip_select_c_n, clock_hold_n, byte_lane_write_n,
    input  burst_order_select, output_enable_n, dq,
    output mem_dq_out, mem_dq_oe
  );

  modport ctl (
    output addr, rw, advance_not_load, chip_select_a_n, chip_select_b,
    output chip_select_c_n, clock_hold_n, byte_lane_write_n,
    output burst_order_select, output_enable_n, ctl_dq_out, ctl_dq_oe,
    input  dq
  );

endinterface

// ### verilog/ssfb_sram.sv
// sram end: synchronous flow-through burst memory behind ssfb_if.mem
// assumes pins come from logic on i_clk, so no synchronisers are needed
// Summary of operation
// - read load drives word in next cycle
// - advance edge steps counter, next word follows
// - new load allowed while last beat shows
// - controller drives each write beat's data
// - store old write data while loading new
// - hold pin high freezes state and outputs
// - suspended read data waits for enabled edge
// - write data sampled only at enabled edge
// - one read word per cycle when streaming
// - deselect finishes pending read, then floats
// - selected only with all three selects true
// - data pins float from power-up
// - burst direction fixed at load time
// - order pin picks interleaved or linear
// - counter wraps after fourth beat
// - each lane write enables nine bits
`timescale 1ns/1ps
`include "ssfb_regs.svh"

module ssfb_sram
  import ssfb_pkg::*;
#(
  parameter int ADDR_W = `SSFB_ADDR_W
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  ssfb_if.mem       bus
);

  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < `SSFB_ADDR_MIN || ADDR_W > `SSFB_ADDR_MAX) begin : g_bad_w
    $error("ssfb_sram: ADDR_W out of range");
  end
  if ($bits(bus.addr) != ADDR_W) begin : g_bad_bus
    $error("ssfb_sram: interface address width differs");
  end

  typedef struct packed {
    logic              burst_on;
    logic              burst_rd;
    logic [ADDR_W-1:0] base;
    ssfb_beat_t        beat;
    logic              pend_wr;
    logic [ADDR_W-1:0] pend_addr;
    ssfb_lanes_t       pend_lanes_n;
    logic              drive;
    ssfb_word_t        rdata;
  } ssfb_mem_st_t;

  ssfb_mem_st_t      st;
  ssfb_mem_st_t      next_st;
  logic              enabled;
  logic              selected;
  logic              fresh;
  logic              fresh_rd;
  logic              fresh_load;
  logic [ADDR_W-1:0] fresh_addr;
  ssfb_beat_t        next_beat;
  ssfb_beat_t        beat_low;
  // nets, since each lane drives its own slice of these
  wire ssfb_word_t   fwd_word;
  wire ssfb_lanes_t  lane_commit;

  // a suspended edge must leave every register untouched
  assign enabled  = !bus.clock_hold_n;
  assign selected = !bus.chip_select_a_n && !bus.chip_select_c_n &&
                    bus.chip_select_b;

  // decode what this edge starts: a fresh beat, its direction and address
  always_comb begin
    fresh      = 1'b0;
    fresh_rd   = 1'b0;
    fresh_load = 1'b0;
    fresh_addr = bus.addr;
    next_beat  = ssfb_beat_t'(st.beat + 2'h1);
    if (bus.burst_order_select) begin
      beat_low = st.base[`SSFB_BEAT_W-1:0] ^ next_beat;
    end else begin
      beat_low = ssfb_beat_t'(st.base[`SSFB_BEAT_W-1:0] + next_beat);
    end
    if (enabled) begin
      if (!bus.advance_not_load) begin
        if (selected) begin
          fresh      = 1'b1;
          fresh_load = 1'b1;
          fresh_rd   = bus.rw;
        end
      end else if (st.burst_on) begin
        fresh      = 1'b1;
        fresh_rd   = st.burst_rd;
        fresh_addr = {st.base[ADDR_W-1:`SSFB_BEAT_W], beat_low};
      end
    end
  end

  // storage is one flip-flop array per nine-bit lane
  for (genvar i = 0; i < `SSFB_LANES; i++) begin : g_lane
    logic [`SSFB_LANE_W-1:0] lane_mem [DEPTH];
    logic [`SSFB_LANE_W-1:0] lane_in;

    assign lane_in = {bus.dq[`SSFB_PAR_BASE + i],
                      bus.dq[i*`SSFB_BYTE_W +: `SSFB_BYTE_W]};
    // pending write data is taken only on an enabled edge
    assign lane_commit[i] = enabled && !i_rst && st.pend_wr &&
                            !st.pend_lanes_n[i];

    always_ff @(posedge i_clk) begin
      if (lane_commit[i]) begin
        lane_mem[st.pend_addr] <= lane_in;
      end
    end

    // a read of the word being written this edge sees the new lane
    assign {fwd_word[`SSFB_PAR_BASE + i],
            fwd_word[i*`SSFB_BYTE_W +: `SSFB_BYTE_W]} =
      (lane_commit[i] && st.pend_addr == fresh_addr) ? lane_in
                                                     : lane_mem[fresh_addr];
  end

  always_comb begin
    next_st = st;
    if (enabled) begin
      if (!bus.advance_not_load) begin
        // a deselect stops any burst; a load starts a new one
        next_st.burst_on = fresh_load;
        if (fresh_load) begin
          next_st.burst_rd = bus.rw;
          next_st.base     = bus.addr;
          next_st.beat     = '0;
        end
      end else if (st.burst_on) begin
        next_st.beat = next_beat;
      end
      next_st.pend_wr      = fresh && !fresh_rd;
      next_st.pend_addr    = fresh_addr;
      next_st.pend_lanes_n = bus.byte_lane_write_n;
      // read word is captured at the load or advance edge and shown straight after
      next_st.drive = fresh && fresh_rd;
      if (fresh && fresh_rd) begin
        next_st.rdata = fwd_word;
      end
    end
  end

  // reset stands in for power-up: nothing pending, pins floating
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.mem_dq_out = st.rdata;
  // output enable needs no clock edge to take effect
  assign bus.mem_dq_oe  = st.drive && !bus.output_enable_n;

endmodule

// ### tb/ssfb_link_props.sv
// checker on the pin link between the controller end and the sram end
// assumes it sits beside ssfb_if and sees the same i_clk and i_rst
`timescale 1ns/1ps
module ssfb_link_props
  import ssfb_pkg::*;
(
  input wire logic  i_clk,
  input wire logic  i_rst,
  input wire logic  rw,
  input wire logic  advance_not_load,
  input wire logic  chip_select_a_n,
  input wire logic  chip_select_b,
  input wire logic  chip_select_c_n,
  input wire logic  clock_hold_n,
  input wire logic  output_enable_n,
  input ssfb_word_t mem_dq_out,
  input wire logic  mem_dq_oe,
  input wire logic  ctl_dq_oe,
  input wire logic  dq_contention
);
  logic en;
  logic sel;
  logic ld;
  assign en  = !clock_hold_n;
  assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign ld  = en && !advance_not_load;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_NO_FIGHT: assert property (!dq_contention)
    else $error("both ends drive the data bus");
  AST_OE_GATE: assert property (mem_dq_oe |-> !output_enable_n)
    else $error("sram drives with output enable high");
  AST_READ_NEXT: assert property (ld && sel && rw |=> mem_dq_oe)
    else $error("read load not driven next cycle");
  AST_BURST_READ: assert property (
    ld && sel && rw ##1 (en && advance_not_load) |=> mem_dq_oe)
    else $error("burst beat not driven");
  AST_HOLD_FREEZE: assert property (!en |=> $stable(mem_dq_out))
    else $error("read word moved on a held edge");
  AST_DESEL_FLOAT: assert property (
    ld && !sel ##1 (en && !(ld && sel && rw)) |=> !mem_dq_oe)
    else $error("bus not floated after deselect");
  AST_WRITE_QUIET: assert property (
    ld && sel && !rw |=> !mem_dq_oe && ctl_dq_oe)
    else $error("write beat bus ownership wrong");
  AST_WRITE_DIR: assert property (
    ld && sel && !rw ##1 (en && advance_not_load) |=> !mem_dq_oe)
    else $error("write burst turned into read");
  AST_POWER_UP: assert property (
    @(posedge i_clk) disable iff (1'b0) i_rst |=> !mem_dq_oe)
    else $error("sram drives during power-up");
endmodule

// ### tb/tb_top.sv
// bench: controller end joined to sram end, driven from the user port
// assumes ssfb_pkg, ssfb_if and both design ends are compiled first
`timescale 1ns/1ps
module tb_top;
  import ssfb_pkg::*;
  localparam ssfb_op_t ld_c = SSFB_OP_LOAD;
  localparam ssfb_op_t ad_c = SSFB_OP_ADV;
  localparam ssfb_op_t ds_c = SSFB_OP_DESEL;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_cmd_valid = 1'b0;
  logic        i_cmd_write = 1'b0;
  logic        i_hold = 1'b0;
  logic        i_burst_order = 1'b0;
  ssfb_op_t    i_cmd_op = SSFB_OP_DESEL;
  logic [7:0]  i_cmd_addr = 8'h00;
  ssfb_lanes_t i_cmd_lanes_n = 4'hf;
  ssfb_word_t  i_wdata = 36'h0;
  ssfb_word_t  o_rdata;
  logic        o_cmd_ready;
  logic        o_rvalid;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [31:0] rng = 32'h7ca9ce24;
  ssfb_word_t  mem [256];
  ssfb_word_t  exp_q [$];
  logic [7:0]  base, pa, ca;
  logic [1:0]  beat;
  ssfb_lanes_t pl;
  logic        rd = 1'b0, act = 1'b0, pend = 1'b0;

  ssfb_if #(.ADDR_W(8)) bus ();
  ssfb_sram #(.ADDR_W(8)) i_ssfb_sram (
    .i_clk(i_clk), .i_rst(i_rst), .bus(bus));
  ssfb_ctl #(.ADDR_W(8)) i_ssfb_ctl (
    .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_write(i_cmd_write),
    .i_cmd_addr(i_cmd_addr), .i_cmd_lanes_n(i_cmd_lanes_n),
    .i_wdata(i_wdata), .i_hold(i_hold), .i_burst_order(i_burst_order),
    .o_cmd_ready(o_cmd_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .bus(bus));
  ssfb_link_props i_ssfb_link_props (
    .i_clk(i_clk), .i_rst(i_rst), .rw(bus.rw),
    .advance_not_load(bus.advance_not_load),
    .chip_select_a_n(bus.chip_select_a_n),
    .chip_select_b(bus.chip_select_b),
    .chip_select_c_n(bus.chip_select_c_n),
    .clock_hold_n(bus.clock_hold_n),
    .output_enable_n(bus.output_enable_n),
    .mem_dq_out(bus.mem_dq_out), .mem_dq_oe(bus.mem_dq_oe),
    .ctl_dq_oe(bus.ctl_dq_oe), .dq_contention(bus.dq_contention));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk_word(ssfb_word_t e, ssfb_word_t g);
    samples_checked++;
    if (e !== g) begin
      err_total++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_bit(logic e, logic g);
    chk_word(ssfb_word_t'(e), ssfb_word_t'(g));
  endtask

  // one user cycle; data given here belongs to the previous write beat
  task automatic st(ssfb_op_t op, logic wr, logic [7:0] a,
                    ssfb_lanes_t ln, logic hd);
    ssfb_word_t d;
    d = ssfb_word_t'({rnd(), rnd()});
    if (pend) begin
      for (int i = 0; i < 4; i++) begin
        if (!pl[i]) mem[pa][8*i+:8] = d[8*i+:8];
        if (!pl[i]) mem[pa][32+i] = d[32+i];
      end
      pend = 1'b0;
    end
    if (!hd && op == ld_c) begin
      base = a;
      beat = 2'h0;
      rd = wr ? 1'b0 : 1'b1;
      act = 1'b1;
    end else if (!hd && op == ad_c) beat++;
    else if (!hd) act = 1'b0;
    if (!hd && act) begin
      ca = {base[7:2], i_burst_order ? base[1:0] ^ beat
                                     : base[1:0] + beat};
      if (rd) exp_q.push_back(mem[ca]);
      else begin
        pend = 1'b1;
        pa = ca;
        pl = ln;
      end
    end
    i_cmd_valid = 1'b1;
    i_cmd_op = op;
    i_cmd_write = wr;
    i_cmd_addr = a;
    i_cmd_lanes_n = ln;
    i_wdata = d;
    i_hold = hd;
    #1 chk_bit(!hd, o_cmd_ready);
    @(posedge i_clk);
    #1;
  endtask

  task automatic adv(int n, logic hd);
    repeat (n) st(ad_c, 1'b0, 8'h00, 4'h0, hd);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (i_rst) chk_bit(1'b1, bus.dq_floating);
    if (bus.mem_dq_oe === 1'b1) chk_word(bus.mem_dq_out, bus.dq);
    if (!i_rst && o_rvalid === 1'b1) begin
      chk_bit(1'b1, exp_q.size() > 0);
      if (exp_q.size() > 0) chk_word(exp_q.pop_front(), o_rdata);
    end
  end

  initial begin
    #20000;
    err_total++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    #1 i_rst = 1'b0;
    st(ld_c, 1'b1, 8'h11, 4'h0, 1'b0);
    adv(1, 1'b0);
    adv(1, 1'b1);
    adv(3, 1'b0);
    st(ld_c, 1'b1, 8'h20, 4'h0, 1'b0);
    st(ld_c, 1'b1, 8'h20, ssfb_lanes_t'(rnd()), 1'b0);
    st(ld_c, 1'b0, 8'h20, 4'h0, 1'b0);
    st(ld_c, 1'b0, 8'h11, 4'h0, 1'b0);
    adv(4, 1'b0);
    st(ld_c, 1'b0, 8'h12, 4'h0, 1'b0);
    adv(2, 1'b1);
    adv(2, 1'b0);
    repeat (4) st(ds_c, 1'b0, 8'h00, 4'h0, 1'b0);
    chk_bit(1'b1, bus.dq_floating);
    i_burst_order = 1'b1;
    st(ld_c, 1'b0, 8'h12, 4'h0, 1'b0);
    adv(3, 1'b0);
    for (int k = 0; k < 4; k++) st(ld_c, 1'b0, 8'h10 + 8'(k), 4'h0, 1'b0);
    repeat (60) begin
      rnd();
      st(rng[1] ? ld_c : (rng[2] ? ad_c : ds_c), rng[3],
         {6'h04, rng[5:4]}, ssfb_lanes_t'(rng[9:6]), rng[11:10] == 2'h0);
    end
    repeat (6) st(ds_c, 1'b0, 8'h00, 4'h0, 1'b0);
    chk_bit(1'b1, exp_q.size() == 0);
    conclude();
  end
endmodule
